//--- hdl/cbt_can_tx.sv
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cbt_defines.svh"

module cbt_can_tx (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire cbt_pkg::cbt_wb_req_t wb_req_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     irq_o,
  input  wire logic                rx_i,
  output logic                     tx_o
);
  import cbt_pkg::*;

  localparam int FW = 103;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        o[8*b +: 8] = n[8*b +: 8];
      end
    end
    return o;
  endfunction : merge

  function automatic logic [5:0] min6(input logic [5:0] a, input logic [5:0] b);
    return (a < b) ? a : b;
  endfunction : min6

  function automatic cbt_timing_t unpack_timing(input logic [31:0] w);
    return '{baud_prescale_value: w[9:0], resync_jump_width: w[15:14], time_segment_one: w[19:16], time_segment_two: w[22:20]};
  endfunction : unpack_timing

  function automatic logic [28:0] sched_key(input logic [31:0] info, input logic [31:0] idw,
                                            input logic mode);
    if (mode) begin
      return {21'h0, info[7:0]};
    end
    return info[`CBT_INFO_EXT_BIT] ? idw[28:0] : {idw[10:0], 18'h0};
  endfunction : sched_key

  logic [31:0] buf_mem_reg [12];
  logic [2:0]  pend_reg;
  logic [2:0]  srx_reg;
  logic        prio_mode_reg;
  cbt_timing_t timing_reg;
  logic [4:0]  istat_reg;
  logic [4:0]  imask_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;

  // Bus decode. Every access is acked one cycle after it is seen.
  logic       req, wr, rd, in_buf;
  logic [7:0] boff;
  logic [3:0] buf_idx;
  assign req     = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
  assign wr      = req & wb_req_i.we;
  assign rd      = req & ~wb_req_i.we;
  assign in_buf  = (wb_req_i.adr >= `CBT_ADR_BUF_LO) && (wb_req_i.adr <= `CBT_ADR_BUF_HI);
  assign boff    = wb_req_i.adr - `CBT_ADR_BUF_LO;
  assign buf_idx = boff[5:2];

  // Bit timing state.
  logic [9:0] presc_reg;
  logic [5:0] pos_reg, seg1_end_reg, bit_end_reg;
  logic       rxq_reg;
  logic       tq_tick, bit_start, sample_pt, edge_ok, hard_sync;
  logic [5:0] nom_s1, nom_be, sjw_q, jump_late, jump_early;

  // Transmit engine state.
  cbt_state_t   state_reg;
  logic [FW-1:0] sh_reg;
  logic [6:0]   remain_reg;
  logic         in_crc_reg;
  logic [14:0]  crc_reg, crc_nx;
  logic [2:0]   run_reg;
  logic         last_reg, tx_reg, stuff_reg, cur_arb_reg;
  logic [5:0]   arb_left_reg;
  logic [3:0]   tail_reg, idle_cnt_reg;
  logic [1:0]   cur_buf_reg;
  logic [2:0]   done_reg;
  logic         ev_arb_reg, ev_err_reg, bus_idle, start_frame;

  // Scheduler and frame builder.
  logic [1:0]    best_i;
  logic [28:0]   best_key;
  logic          found;
  logic [31:0]   s_info, s_id, s_da, s_db;
  logic [3:0]    s_dlc, s_nbytes;
  logic [63:0]   s_data;
  logic [FW-1:0] s_vec;
  logic [6:0]    s_len;

  assign tq_tick   = presc_reg >= timing_reg.baud_prescale_value;
  assign nom_s1    = 6'(timing_reg.time_segment_one) + 6'h01;
  assign nom_be    = nom_s1 + 6'(timing_reg.time_segment_two) + 6'h01;
  assign sjw_q     = 6'(timing_reg.resync_jump_width) + 6'h01;
  assign jump_late  = min6(pos_reg, sjw_q);
  assign jump_early = min6(bit_end_reg - pos_reg, sjw_q);
  assign bit_start = tq_tick && (pos_reg >= bit_end_reg);
  assign sample_pt = tq_tick && (pos_reg == seg1_end_reg);
  assign edge_ok   = rxq_reg & ~rx_i & tx_reg;
  assign hard_sync = (state_reg == CBT_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_reg    <= 10'h000;
      pos_reg      <= 6'h00;
      seg1_end_reg <= 6'h04;
      bit_end_reg  <= 6'h07;
      rxq_reg      <= 1'b1;
    end else begin
      presc_reg <= tq_tick ? 10'h000 : presc_reg + 10'h001;
      if (tq_tick) begin
        rxq_reg <= rx_i;
        if (pos_reg >= bit_end_reg) begin
          pos_reg      <= 6'h00;
          seg1_end_reg <= nom_s1;
          bit_end_reg  <= nom_be;
        end else if (edge_ok && hard_sync) begin
          pos_reg      <= 6'h01;
          seg1_end_reg <= nom_s1;
          bit_end_reg  <= nom_be;
        end else begin
          pos_reg <= pos_reg + 6'h01;
          if (edge_ok && (pos_reg <= seg1_end_reg)) begin
            seg1_end_reg <= seg1_end_reg + jump_late;
            bit_end_reg  <= bit_end_reg + jump_late;
          end else if (edge_ok) begin
            bit_end_reg <= bit_end_reg - jump_early;
          end
        end
      end
    end
  end

  // Eleven recessive samples in a row mean nobody else owns the bus.
  assign bus_idle = (idle_cnt_reg == `CBT_IDLE_BITS);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt_reg <= 4'h0;
    end else if (sample_pt) begin
      idle_cnt_reg <= !rx_i ? 4'h0 : (bus_idle ? idle_cnt_reg : idle_cnt_reg + 4'h1);
    end
  end

  always_comb begin
    best_i   = 2'h0;
    best_key = 29'h0;
    found    = 1'b0;
    for (int i = 0; i < 3; i++) begin
      // Strict compare keeps the lower-numbered buffer on a tie.
      if (pend_reg[i] && (!found || sched_key(buf_mem_reg[4*i], buf_mem_reg[4*i+1],
          prio_mode_reg) < best_key)) begin
        best_i   = 2'(i);
        best_key = sched_key(buf_mem_reg[4*i], buf_mem_reg[4*i+1], prio_mode_reg);
        found    = 1'b1;
      end
    end
  end

  always_comb begin
    s_info   = buf_mem_reg[{best_i, 2'h0}];
    s_id     = buf_mem_reg[{best_i, 2'h1}];
    s_da     = buf_mem_reg[{best_i, 2'h2}];
    s_db     = buf_mem_reg[{best_i, 2'h3}];
    s_dlc    = s_info[`CBT_INFO_DLC_MSB:`CBT_INFO_DLC_LSB];
    s_nbytes = s_info[`CBT_INFO_RTR_BIT] ? 4'h0 :
               ((s_dlc > 4'h8) ? 4'h8 : s_dlc);
    s_data   = {s_da[7:0], s_da[15:8], s_da[23:16], s_da[31:24],
                s_db[7:0], s_db[15:8], s_db[23:16], s_db[31:24]};
    if (s_info[`CBT_INFO_EXT_BIT]) begin
      s_vec = {1'b0, s_id[28:18], 2'h3, s_id[17:0], s_info[`CBT_INFO_RTR_BIT], 2'h0, s_dlc,
               s_data};
      s_len = `CBT_HDR_EXT + {s_nbytes, 3'h0};
    end else begin
      s_vec = {1'b0, s_id[10:0], s_info[`CBT_INFO_RTR_BIT], 2'h0, s_dlc, s_data, 20'h0};
      s_len = `CBT_HDR_STD + {s_nbytes, 3'h0};
    end
  end

  assign crc_nx = {crc_reg[13:0], 1'b0} ^
                  ((sh_reg[FW-1] ^ crc_reg[14]) ? `CBT_CRC_POLY : 15'h0000);
  assign start_frame = bit_start && (state_reg == CBT_IDLE) && bus_idle && found;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= CBT_IDLE;
      sh_reg       <= '0;
      remain_reg   <= 7'h00;
      in_crc_reg   <= 1'b0;
      crc_reg      <= 15'h0000;
      run_reg      <= 3'h0;
      last_reg     <= 1'b1;
      tx_reg       <= 1'b1;
      stuff_reg    <= 1'b0;
      cur_arb_reg  <= 1'b0;
      arb_left_reg <= 6'h00;
      tail_reg     <= 4'h0;
      cur_buf_reg  <= 2'h0;
      done_reg     <= 3'h0;
      ev_arb_reg   <= 1'b0;
      ev_err_reg   <= 1'b0;
    end else begin
      done_reg   <= 3'h0;
      ev_arb_reg <= 1'b0;
      ev_err_reg <= 1'b0;
      unique case (state_reg)
        CBT_IDLE: begin
          // A fresh pick for every frame, so a retry may yield to a newer request.
          if (start_frame) begin
            state_reg    <= CBT_FRAME;
            sh_reg       <= s_vec;
            remain_reg   <= s_len;
            in_crc_reg   <= 1'b0;
            crc_reg      <= 15'h0000;
            run_reg      <= 3'h0;
            last_reg     <= 1'b1;
            cur_buf_reg  <= best_i;
            arb_left_reg <= s_info[`CBT_INFO_EXT_BIT] ? `CBT_ARB_EXT : `CBT_ARB_STD;
          end
        end
        CBT_FRAME: begin
          if (sample_pt && (rx_i != tx_reg)) begin
            ev_arb_reg <= cur_arb_reg && tx_reg && !stuff_reg;
            ev_err_reg <= !(cur_arb_reg && tx_reg && !stuff_reg);
            state_reg  <= CBT_IDLE;
            tx_reg     <= 1'b1;
          end else if (bit_start && (run_reg == `CBT_STUFF_RUN)) begin
            tx_reg    <= ~last_reg;
            last_reg  <= ~last_reg;
            run_reg   <= 3'h1;
            stuff_reg <= 1'b1;
          end else if (bit_start && (remain_reg == 7'h00)) begin
            state_reg <= CBT_TAIL;
            tail_reg  <= 4'h0;
            tx_reg    <= 1'b1;
            stuff_reg <= 1'b0;
          end else if (bit_start) begin
            tx_reg       <= sh_reg[FW-1];
            stuff_reg    <= 1'b0;
            last_reg     <= sh_reg[FW-1];
            run_reg      <= (sh_reg[FW-1] == last_reg) ? run_reg + 3'h1 : 3'h1;
            cur_arb_reg  <= (arb_left_reg != 6'h00);
            arb_left_reg <= (arb_left_reg != 6'h00) ? arb_left_reg - 6'h01 : 6'h00;
            if (!in_crc_reg) begin
              crc_reg <= crc_nx;
            end
            if (!in_crc_reg && (remain_reg == 7'h01)) begin
              sh_reg     <= {crc_nx, 88'h0};
              remain_reg <= 7'h0F;
              in_crc_reg <= 1'b1;
            end else begin
              sh_reg     <= {sh_reg[FW-2:0], 1'b0};
              remain_reg <= remain_reg - 7'h01;
            end
          end
        end
        CBT_TAIL: begin
          if (bit_start) begin
            tail_reg <= tail_reg + 4'h1;
          end
          if (sample_pt) begin
            if ((tail_reg == `CBT_TAIL_ACK) && rx_i && !srx_reg[cur_buf_reg]) begin
              ev_err_reg <= 1'b1;
              state_reg  <= CBT_IDLE;
            end else if ((tail_reg != `CBT_TAIL_ACK) && (tail_reg <= `CBT_TAIL_EOF_END)
                         && !rx_i) begin
              ev_err_reg <= 1'b1;
              state_reg  <= CBT_IDLE;
            end else if (tail_reg == `CBT_TAIL_LAST) begin
              done_reg[cur_buf_reg] <= 1'b1;
              state_reg             <= CBT_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign tx_o = tx_reg;

  // A buffer locks while pending; writes to it are dropped so the frame stays intact.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= 3'h0;
      srx_reg  <= 3'h0;
    end else begin
      if (wr && (wb_req_i.adr == `CBT_ADR_CMD) && wb_req_i.sel[0]) begin
        pend_reg <= (pend_reg & ~done_reg) | wb_req_i.dat[2:0];
        srx_reg  <= (srx_reg & pend_reg) |
                    (wb_req_i.dat[2:0] & ~pend_reg & {3{wb_req_i.dat[`CBT_CMD_SRX_BIT]}});
      end else begin
        pend_reg <= pend_reg & ~done_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 12; i++) begin
        buf_mem_reg[i] <= 32'h0000_0000;
      end
    end else if (wr && in_buf && !pend_reg[buf_idx[3:2]]) begin
      buf_mem_reg[buf_idx] <= merge(buf_mem_reg[buf_idx], wb_req_i.dat, wb_req_i.sel);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_mode_reg <= 1'b0;
      timing_reg    <= unpack_timing(`CBT_TIMING_RESET);
      imask_reg     <= 5'h00;
    end else if (wr) begin
      if (wb_req_i.adr == `CBT_ADR_MODE && wb_req_i.sel[0]) begin
        prio_mode_reg <= wb_req_i.dat[`CBT_MODE_PRIO_BIT];
      end
      if (wb_req_i.adr == `CBT_ADR_IMASK && wb_req_i.sel[0]) begin
        imask_reg <= wb_req_i.dat[4:0];
      end
      if (wb_req_i.adr == `CBT_ADR_TIMING) begin
        timing_reg <= unpack_timing(merge(rd_timing(), wb_req_i.dat, wb_req_i.sel));
      end
    end
  end

  function automatic logic [31:0] rd_timing();
    return {9'h000, timing_reg.time_segment_two, timing_reg.time_segment_one, timing_reg.resync_jump_width, 4'h0, timing_reg.baud_prescale_value};
  endfunction : rd_timing

  // The read of the status copy and its clear share one edge; a new event still sticks.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      istat_reg <= 5'h00;
    end else begin
      istat_reg <= ((rd && wb_req_i.adr == `CBT_ADR_ISTAT) ? 5'h00 : istat_reg) |
                   {ev_err_reg, ev_arb_reg, done_reg};
    end
  end

  assign irq_o = |(istat_reg & imask_reg);

  always_comb begin
    rdat_next = 32'h0000_0000;
    if (in_buf) begin
      rdat_next = buf_mem_reg[buf_idx];
    end else begin
      case (wb_req_i.adr)
        `CBT_ADR_MODE:   rdat_next = {31'h0, prio_mode_reg};
        `CBT_ADR_STAT:   rdat_next = {27'h0, bus_idle, state_reg != CBT_IDLE, ~pend_reg};
        `CBT_ADR_ISTAT:  rdat_next = {27'h0, istat_reg};
        `CBT_ADR_IMASK:  rdat_next = {27'h0, imask_reg};
        `CBT_ADR_TIMING: rdat_next = rd_timing();
        default:         rdat_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg  <= req;
      rdat_reg <= rd ? rdat_next : rdat_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // Helper counters for the checks below.
  logic [9:0] tq_gap_reg;
  logic [5:0] bit_tq_reg;
  logic       tq_ok_reg, clean_reg, bit_ok_reg, bt_wr;
  assign bt_wr = wr && (wb_req_i.adr == `CBT_ADR_TIMING);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tq_gap_reg <= 10'h000;
      bit_tq_reg <= 6'h00;
      tq_ok_reg  <= 1'b0;
      clean_reg  <= 1'b0;
      bit_ok_reg <= 1'b0;
    end else begin
      tq_gap_reg <= tq_tick ? 10'h000 : tq_gap_reg + 10'h001;
      tq_ok_reg  <= !bt_wr && (tq_tick || tq_ok_reg);
      bit_tq_reg <= bit_start ? 6'h00 : (tq_tick ? bit_tq_reg + 6'h01 : bit_tq_reg);
      clean_reg  <= !bt_wr && !(tq_tick && edge_ok) && (bit_start || clean_reg);
      // New segment lengths only load at a bit boundary, so bounds wait for one.
      bit_ok_reg <= !bt_wr && (bit_start || bit_ok_reg);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_tq_period: assert property (tq_tick && tq_ok_reg |-> tq_gap_reg == timing_reg.baud_prescale_value)
    else $error("time quantum length differs from prescale plus one");
  a_jump_bound: assert property (
      clean_reg || !bit_ok_reg || seg1_end_reg <= nom_s1 + sjw_q)
    else $error("segment one stretched beyond jump width");
  a_late_resync: assert property (
      tq_tick && edge_ok && !hard_sync && pos_reg != 6'h00 && pos_reg <= seg1_end_reg &&
      pos_reg < bit_end_reg |=> seg1_end_reg > $past(seg1_end_reg))
    else $error("late edge did not lengthen the bit");
  a_bit_length: assert property (bit_start && clean_reg |-> bit_tq_reg == nom_be)
    else $error("unsynchronised bit has wrong quantum count");
  a_sample_point: assert property (sample_pt && clean_reg |-> bit_tq_reg == nom_s1)
    else $error("sample point not at end of segment one");
  a_buf_write: assert property (wr && in_buf && !pend_reg[buf_idx[3:2]] && wb_req_i.sel == 4'hF
      |=> buf_mem_reg[$past(buf_idx)] == $past(wb_req_i.dat))
    else $error("free buffer word not written");
  a_free_status: assert property (rd && wb_req_i.adr == `CBT_ADR_STAT
      |=> wb_ack_o && wb_dat_o[2:0] == ~$past(pend_reg))
    else $error("free bits disagree with pending buffers");
  a_remote_len: assert property (start_frame && s_info[`CBT_INFO_RTR_BIT] |=>
      remain_reg == ($past(s_info[`CBT_INFO_EXT_BIT]) ? `CBT_HDR_EXT : `CBT_HDR_STD))
    else $error("remote frame carries data bits");
  a_dlc_cap: assert property (
      start_frame && !s_info[`CBT_INFO_RTR_BIT] && s_dlc > 4'h8 |->
      s_len == (s_info[`CBT_INFO_EXT_BIT] ? `CBT_HDR_EXT : `CBT_HDR_STD) + `CBT_MAX_DATA)
    else $error("long length code did not send exactly eight bytes");
  a_sched_pick: assert property (
      start_frame |-> pend_reg[best_i] && (best_i == 2'h0 || !pend_reg[0] ||
      sched_key(buf_mem_reg[0], buf_mem_reg[1], prio_mode_reg) > best_key))
    else $error("scheduler skipped a better or equal lower buffer");
  a_retry_idle: assert property (ev_arb_reg || ev_err_reg |-> state_reg == CBT_IDLE &&
      pend_reg[cur_buf_reg])
    else $error("failed frame did not return for rescheduling");

  c_ext_start: cover property (start_frame && s_info[`CBT_INFO_EXT_BIT]);
  c_arb_lost:  cover property (ev_arb_reg);
  c_tx_done:   cover property (done_reg != 3'h0);
  c_resync:    cover property (tq_tick && edge_ok && state_reg == CBT_FRAME);
endmodule : cbt_can_tx

//--- pkg/cbt_defines.svh
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH
// Register byte offsets.
`define CBT_ADR_MODE      8'h00
`define CBT_ADR_CMD       8'h04
`define CBT_ADR_STAT      8'h08
`define CBT_ADR_ISTAT     8'h0C
`define CBT_ADR_IMASK     8'h10
`define CBT_ADR_TIMING    8'h14
`define CBT_ADR_BUF_LO    8'h30
`define CBT_ADR_BUF_HI    8'h5C
// Field positions.
`define CBT_MODE_PRIO_BIT 0
`define CBT_CMD_SRX_BIT   4
`define CBT_STAT_ACT_BIT  3
`define CBT_STAT_IDLE_BIT 4
`define CBT_INFO_DLC_MSB  19
`define CBT_INFO_DLC_LSB  16
`define CBT_INFO_RTR_BIT  30
`define CBT_INFO_EXT_BIT  31
`define CBT_IRQ_ARB_BIT   3
`define CBT_IRQ_ERR_BIT   4
// Reset values.
`define CBT_TIMING_RESET  32'h0023_0000
// Frame constants.
`define CBT_IDLE_BITS     4'hB
`define CBT_STUFF_RUN     3'h5
`define CBT_CRC_POLY      15'h4599
`define CBT_HDR_STD       7'h13
`define CBT_HDR_EXT       7'h27
`define CBT_ARB_STD       6'h0D
`define CBT_ARB_EXT       6'h21
`define CBT_MAX_DATA      7'h40
`define CBT_TAIL_ACK      4'h1
`define CBT_TAIL_EOF_END  4'h9
`define CBT_TAIL_LAST     4'hC
`endif

//--- pkg/cbt_pkg.sv
package cbt_pkg;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cbt_wb_req_t;

  typedef struct packed {
    logic [9:0] baud_prescale_value;
    logic [1:0] resync_jump_width;
    logic [3:0] time_segment_one;
    logic [2:0] time_segment_two;
  } cbt_timing_t;

  typedef enum logic [1:0] {CBT_IDLE, CBT_FRAME, CBT_TAIL} cbt_state_t;
endpackage : cbt_pkg

//--- tb/can_bit_timing_tx_buffers_tb.sv
`timescale 1ns/1ps
module can_bit_timing_tx_buffers_tb;
  import cbt_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  cbt_wb_req_t req   = '0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  logic        rx_i;
  logic        tx_o;
  logic [3:0]  dly   = 4'h0;
  logic [31:0] seed  = 32'hC38066B3;
  logic [31:0] q;
  int          miscompares = 0;
  int          tests_run   = 0;
  int          baud_prescale_value, s1, s2, n, best;
  int          key[3];
  int          got[$];
  int          ex[$];
  logic [2:0]  used;

  always #25 clk_i = ~clk_i;

  cbt_can_tx dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o),
                  .wb_ack_o(wb_ack_o), .irq_o(irq_o), .rx_i(rx_i), .tx_o(tx_o));
  cbt_can_node node (.clk_i(clk_i), .tx_i(tx_o), .delay_i(dly), .rx_o(rx_i));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic results();
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    q = wb_dat_o;
    req <= '0;
    if (k >= 50) begin
      miscompares++;
      results();
    end
  endtask : wb

  task automatic wait_tx(input logic lvl);
    n = 0;
    while (tx_o === lvl && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20000) begin
      miscompares++;
      results();
    end
  endtask : wait_tx

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h14, 0);
    chk("timing_reset", q, 32'h0023_0000);
    wb(0, 8'h08, 0);
    chk("free_bits", q[2:0], 3'h7);
    wb(1, 8'h60, 32'hFFFF_FFFF);
    wb(0, 8'h60, 0);
    chk("unmapped", q, 0);
    wb(1, 8'h10, 32'h1);
    // Identifier zero gives SOF plus four dominant bits before the first stuff bit.
    for (int r = 0; r < 3; r++) begin
      baud_prescale_value = rnd() % 4;
      s1 = 2 + rnd() % 6;
      s2 = 1 + rnd() % 3;
      dly <= 4'(rnd() % 3);
      wb(1, 8'h14, {9'h0, 3'(s2), 4'(s1), 6'h0, 10'(baud_prescale_value)});
      // Pass two sends a remote frame, pass three an extended one.
      wb(1, 8'h30, {1'(r == 2), 1'(r == 1), 10'h0, 4'(r), 16'h0});
      wb(1, 8'h34, 0);
      wb(1, 8'h04, 32'h11);
      wait_tx(1'b1);
      wait_tx(1'b0);
      chk("sof_run", n, 5 * (baud_prescale_value + 1) * (3 + s1 + s2));
      n = 0;
      while (irq_o !== 1'b1 && n < 20000) begin
        @(posedge clk_i);
        n++;
      end
      if (n >= 20000) begin
        miscompares++;
        results();
      end
      wb(0, 8'h0C, 0);
      chk("istat", q[4:0], 5'h01);
      @(posedge clk_i);
      chk("irq_clear", irq_o, 0);
    end
    // Without self reception nobody acknowledges, so the frame fails and stays pending.
    wb(1, 8'h04, 32'h01);
    n = 0;
    do begin
      wb(0, 8'h0C, 0);
      n++;
    end while (q[4:0] == 5'h00 && n < 5000);
    if (n >= 5000) begin
      miscompares++;
      results();
    end
    chk("ack_error", q[4:0], 5'h10);
    wb(0, 8'h08, 0);
    chk("retry_pend", q[2:0], 3'h6);
    // A reset in mid-run abandons the retry and restores the default timing.
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h14, 0);
    chk("timing_rst2", q, 32'h0023_0000);
    wb(0, 8'h08, 0);
    chk("free_rst", q[2:0], 3'h7);
    wb(1, 8'h10, 0);
    for (int m = 0; m < 4; m++) begin
      wb(1, 8'h00, m % 2);
      for (int b = 0; b < 3; b++) begin
        key[b] = rnd() % 4;
        wb(1, 8'(8'h30 + 16 * b), {12'h0, 4'(rnd()), 8'h0, 8'(m % 2 ? key[b] : rnd())});
        wb(1, 8'(8'h34 + 16 * b), m % 2 ? rnd() % 2048 : key[b]);
        wb(1, 8'(8'h38 + 16 * b), rnd());
        wb(1, 8'(8'h3C + 16 * b), rnd());
      end
      wb(1, 8'h04, 32'h17);
      wb(0, 8'h08, 0);
      chk("pending", q[2:0], 0);
      ex.delete();
      used = 3'h0;
      for (int k = 0; k < 3; k++) begin
        best = -1;
        for (int b = 0; b < 3; b++)
          if (!used[b] && (best < 0 || key[b] < key[best])) best = b;
        used[best] = 1'b1;
        ex.push_back(best);
      end
      got.delete();
      n = 0;
      while (got.size() < 3 && n < 4000) begin
        chk("irq_masked", irq_o, 0);
        wb(0, 8'h0C, 0);
        for (int b = 0; b < 3; b++)
          if (q[b]) got.push_back(b);
        n++;
      end
      if (got.size() < 3) begin
        miscompares++;
        results();
      end
      for (int k = 0; k < 3; k++) chk("order", got[k], ex[k]);
      wb(0, 8'h08, 0);
      chk("freed", q[2:0], 3'h7);
    end
    results();
  end
endmodule : can_bit_timing_tx_buffers_tb

//--- tb/cbt_can_node.sv
`timescale 1ns/1ps
module cbt_can_node (
  input  wire logic       clk_i,
  input  wire logic       tx_i,
  input  wire logic [3:0] delay_i,
  output logic            rx_o
);
  logic [15:0] hist_reg = 16'hFFFF;

  // This node never drives dominant itself, so the bus shows only the echo of the
  // local transmitter. The delay models a slow transceiver loop.
  always_ff @(posedge clk_i) begin
    hist_reg <= {hist_reg[14:0], tx_i};
  end

  always_comb begin
    rx_o = (delay_i == 4'h0) ? tx_i : hist_reg[delay_i - 4'h1];
  end
endmodule : cbt_can_node
